// ---- common/pdm_pkg.sv ----
package pdm_pkg;

    // ------------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PDM_OFS_REQ_TOTAL_B0 = 8'hBC;
    localparam logic [7:0] PDM_OFS_REQ_TOTAL_B1 = 8'hBD;
    localparam logic [7:0] PDM_OFS_REQ_TOTAL_B2 = 8'hBE;
    localparam logic [7:0] PDM_OFS_REQ_TOTAL_B3 = 8'hBF;
    localparam logic [7:0] PDM_OFS_LONGEST_B0 = 8'hC0;
    localparam logic [7:0] PDM_OFS_LONGEST_B1 = 8'hC1;
    localparam logic [7:0] PDM_OFS_CONTROL = 8'hDF;

    localparam int PDM_ENABLE_BIT = 0;
    localparam logic [31:0] PDM_REQ_TOTAL_RST = 32'h0000_0000;
    localparam logic [15:0] PDM_LONGEST_RST = 16'h0000;
    localparam logic PDM_ENABLE_RST = 1'b0;
    localparam logic [7:0] PDM_RDATA_RST = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        PDM_IDLE,
        PDM_IN_BURST
    } pdm_burst_state_e;

    typedef struct packed {
        logic burst_active;
        logic dw_phase;
        logic request;
    } pdm_event_s;

    typedef struct packed {
        logic req_pulse;
        logic burst_end;
        logic [15:0] burst_dw;
    } pdm_meter_s;

endpackage

// ---- logic/pdm_burst_meter.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdm_burst_meter
    import pdm_pkg::*;
#(
    parameter int DW_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire pdm_event_s evt,
    output pdm_meter_s meter
);

    // ------------------------------------------------------------------
    // Burst tracking and request edge detection
    // ------------------------------------------------------------------
    pdm_burst_state_e state_q, state_d;
    logic [DW_WIDTH-1:0] dw_cnt_q, dw_cnt_d;
    logic req_prev_q;
    logic end_q, end_d;
    logic pulse_q, pulse_d;
    logic [DW_WIDTH-1:0] last_q, last_d;

    always_comb begin
        state_d = state_q;
        dw_cnt_d = dw_cnt_q;
        end_d = 1'b0;
        last_d = last_q;
        // Only a rising request inside an enabled write burst counts.
        pulse_d = enable && evt.burst_active && evt.request && !req_prev_q;
        case (state_q)
            PDM_IDLE: begin
                dw_cnt_d = '0;
                if (evt.burst_active) begin
                    state_d = PDM_IN_BURST;
                    if (enable && evt.dw_phase) begin
                        dw_cnt_d = DW_WIDTH'(1);
                    end
                end
            end
            PDM_IN_BURST: begin
                if (!evt.burst_active) begin
                    state_d = PDM_IDLE;
                    end_d = enable;
                    last_d = dw_cnt_q;
                end else if (enable && evt.dw_phase && !(&dw_cnt_q)) begin
                    dw_cnt_d = dw_cnt_q + DW_WIDTH'(1);
                end
            end
            default: begin
                state_d = PDM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= PDM_IDLE;
            dw_cnt_q <= '0;
            req_prev_q <= 1'b0;
            end_q <= 1'b0;
            pulse_q <= 1'b0;
            last_q <= '0;
        end else begin
            state_q <= state_d;
            dw_cnt_q <= dw_cnt_d;
            req_prev_q <= evt.request;
            end_q <= end_d;
            pulse_q <= pulse_d;
            last_q <= last_d;
        end
    end

    assign meter.req_pulse = pulse_q;
    assign meter.burst_end = end_q;
    assign meter.burst_dw = 16'(last_q);

endmodule

`default_nettype wire

// ---- logic/pci_dma_perf_monitor.sv ----
// How it works
// - A 32-bit total counts bus requests raised during write-invalidate FIFO bursts.
// - The request total wraps from all ones back to zero and keeps counting.
// - A 16-bit record keeps the most doublewords seen in one write burst.
// - Reading the high byte of the longest-burst record returns it, then clears it to zero unless an enabled burst with a nonzero count ends in that cycle.
// - Sequencer or host may set or clear the single monitoring enable bit.
// - The enable gates every monitor counter, including those kept in other blocks.
// - With enable at one, counters count only during write bursts (WR_BURST_ACTIVE high).
// - Other blocks gate burst, latency and SCSI tick counts with the same enable.
// - With enable at zero every counter holds its value; the longest record still clears on read.
// - Counters stay frozen while disabled, but the burst state, request edge and last-burst registers keep toggling.
// - Control bits 7 to 1 read zero; the enable resets to zero.
`timescale 1ns/1ps
`default_nettype none

module pci_dma_perf_monitor
    import pdm_pkg::*;
#(
    parameter int DW_WIDTH = 16
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic BUS_REQUEST_LINE,
    input wire logic WR_BURST_ACTIVE,
    input wire logic DW_PHASE,
    output logic MONITOR_UPDATE_ENABLE
);

    // ------------------------------------------------------------------
    // Burst meter
    // ------------------------------------------------------------------
    pdm_event_s evt;
    pdm_meter_s meter;
    logic enable_q, enable_d;

    assign evt.burst_active = WR_BURST_ACTIVE;
    assign evt.dw_phase = DW_PHASE;
    assign evt.request = BUS_REQUEST_LINE;

    pdm_burst_meter #(
        .DW_WIDTH(DW_WIDTH)
    ) u_meter (
        .clk(SYS_CLK),
        .rst(RESET),
        .enable(enable_q),
        .evt(evt),
        .meter(meter)
    );

    // ------------------------------------------------------------------
    // Counters and control register
    // ------------------------------------------------------------------
    logic [31:0] req_total_q, req_total_d;
    logic [15:0] longest_q, longest_d;
    logic [7:0] rdata_q, rdata_d;
    logic clr_longest;
    logic [15:0] longest_base;

    assign clr_longest = REG_RD && (REG_ADDR == PDM_OFS_LONGEST_B1);

    always_comb begin
        enable_d = enable_q;
        req_total_d = req_total_q;
        longest_d = longest_q;
        longest_base = longest_q;
        if (REG_WR && (REG_ADDR == PDM_OFS_CONTROL)) begin
            enable_d = REG_WDATA[PDM_ENABLE_BIT];
        end
        if (enable_q && meter.req_pulse) begin
            req_total_d = req_total_q + 32'h0000_0001;
        end
        if (clr_longest) begin
            longest_base = 16'h0000;
            longest_d = 16'h0000;
        end
        if (enable_q && meter.burst_end && (16'(meter.burst_dw) > longest_base)) begin
            longest_d = 16'(meter.burst_dw);
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (REG_RD) begin
            if (REG_ADDR == PDM_OFS_REQ_TOTAL_B0) begin
                rdata_d = req_total_q[7:0];
            end else if (REG_ADDR == PDM_OFS_REQ_TOTAL_B1) begin
                rdata_d = req_total_q[15:8];
            end else if (REG_ADDR == PDM_OFS_REQ_TOTAL_B2) begin
                rdata_d = req_total_q[23:16];
            end else if (REG_ADDR == PDM_OFS_REQ_TOTAL_B3) begin
                rdata_d = req_total_q[31:24];
            end else if (REG_ADDR == PDM_OFS_LONGEST_B0) begin
                rdata_d = longest_q[7:0];
            end else if (REG_ADDR == PDM_OFS_LONGEST_B1) begin
                rdata_d = longest_q[15:8];
            end else if (REG_ADDR == PDM_OFS_CONTROL) begin
                rdata_d = {7'h00, enable_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            enable_q <= PDM_ENABLE_RST;
            req_total_q <= PDM_REQ_TOTAL_RST;
            longest_q <= PDM_LONGEST_RST;
            rdata_q <= PDM_RDATA_RST;
        end else begin
            enable_q <= enable_d;
            req_total_q <= req_total_d;
            longest_q <= longest_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;
    // Neighbouring read-side, latency and SCSI counters use this gate.
    assign MONITOR_UPDATE_ENABLE = enable_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_req_held;
        BUS_REQUEST_LINE ##1 BUS_REQUEST_LINE ##1 BUS_REQUEST_LINE;
    endsequence

    sequence s_fresh_req;
        !BUS_REQUEST_LINE ##1 (BUS_REQUEST_LINE && WR_BURST_ACTIVE && enable_q);
    endsequence

    property p_req_count;
        s_fresh_req ##0 $stable(enable_q) |=> ##1 (req_total_q == $past(req_total_q) + 32'h1);
    endproperty
    a_req_count: assert property (p_req_count) else $error("request not counted");

    property p_req_wrap;
        (req_total_q == 32'hFFFF_FFFF && enable_q && meter.req_pulse) |=> (req_total_q == 32'h0);
    endproperty
    a_req_wrap: assert property (p_req_wrap) else $error("request total did not wrap");

    property p_req_once;
        s_req_held |=> $stable(req_total_q);
    endproperty
    a_req_once: assert property (p_req_once) else $error("held request counted twice");

    property p_hold_disabled;
        (!enable_q && !enable_d && !clr_longest) [*2] |=> $stable(req_total_q) && $stable(longest_q);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("counter moved while off");

    property p_clear_on_read;
        (clr_longest && !meter.burst_end) |=> (longest_q == 16'h0);
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("longest not cleared");

    property p_longest_grow;
        (enable_q && meter.burst_end && !clr_longest && meter.burst_dw > longest_q)
            |=> (longest_q == $past(meter.burst_dw));
    endproperty
    a_longest_grow: assert property (p_longest_grow) else $error("longest not replaced");

    property p_longest_keep;
        (meter.burst_end && !clr_longest && meter.burst_dw <= longest_q) |=> $stable(longest_q);
    endproperty
    a_longest_keep: assert property (p_longest_keep) else $error("longest shrank");

    property p_ctrl_read;
        (REG_RD && REG_ADDR == PDM_OFS_CONTROL)
            |=> (REG_RDATA[7:1] == 7'h00) && (REG_RDATA[0] == $past(enable_q));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_ctrl_write;
        (REG_WR && REG_ADDR == PDM_OFS_CONTROL)
            |=> (MONITOR_UPDATE_ENABLE == $past(REG_WDATA[PDM_ENABLE_BIT]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("enable write lost");

endmodule

`default_nettype wire

// ---- testbench/pdm_bus_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdm_bus_partner (
    input wire logic clk,
    output logic req,
    output logic burst,
    output logic dw
);

    // ------------------------------------------------------------------
    // Write burst with one data phase a cycle and spaced requests.
    // ------------------------------------------------------------------
    initial begin
        req = 1'b0;
        burst = 1'b0;
        dw = 1'b0;
    end

    task automatic run(input int dws, input int reqs, input bit hold);
        for (int i = 0; i < dws; i++) begin
            @(posedge clk);
            #1;
            burst = 1'b1;
            dw = 1'b1;
            req = (i > 0) && (hold || (i < 2 * reqs && i % 2 == 1));
        end
        @(posedge clk);
        #1;
        burst = 1'b0;
        dw = 1'b0;
        req = 1'b0;
        repeat (4) @(posedge clk);
    endtask

endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pdm_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic en;
    wire logic req;
    wire logic burst;
    wire logic dw;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] v;

    always #2.5 clk = ~clk;

    pci_dma_perf_monitor #(.DW_WIDTH(16)) i_dut (
        .SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .BUS_REQUEST_LINE(req),
        .WR_BURST_ACTIVE(burst), .DW_PHASE(dw), .MONITOR_UPDATE_ENABLE(en)
    );

    pdm_bus_partner i_far (.clk(clk), .req(req), .burst(burst), .dw(dw));

    // ------------------------------------------------------------------
    // Register access and comparison.
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic rd_n(input logic [7:0] a, input int n, output logic [31:0] t);
        logic [7:0] b;
        t = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            rd8(a + 8'(i), b);
            t[8*i+:8] = b;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_n(PDM_OFS_CONTROL, 1, v);
        chk("control", 32'h0000_0000, v);
        chk("enable", 32'h0000_0000, {31'h0, en});
        rd_n(PDM_OFS_REQ_TOTAL_B0, 4, v);
        chk("total", 32'h0000_0000, v);
        rd_n(PDM_OFS_LONGEST_B0, 2, v);
        chk("longest", 32'h0000_0000, v);
    endtask

    task automatic t_control();
        wr8(PDM_OFS_CONTROL, 8'hFF);
        chk("enable", 32'h0000_0001, {31'h0, en});
        rd_n(PDM_OFS_CONTROL, 1, v);
        chk("control", 32'h0000_0001, v);
        wr8(PDM_OFS_CONTROL, 8'h00);
        chk("enable", 32'h0000_0000, {31'h0, en});
        wr8(PDM_OFS_REQ_TOTAL_B0, 8'h55);
        rd_n(PDM_OFS_REQ_TOTAL_B0, 1, v);
        chk("total_b0", 32'h0000_0000, v);
        rd_n(8'h10, 1, v);
        chk("unmapped", 32'h0000_0000, v);
    endtask

    task automatic t_count();
        wr8(PDM_OFS_CONTROL, 8'h01);
        i_far.run(8, 3, 1'b0);
        i_far.run(6, 1, 1'b1);
        wr8(PDM_OFS_CONTROL, 8'h00);
        rd_n(PDM_OFS_REQ_TOTAL_B0, 4, v);
        chk("total", 32'h0000_0004, v);
        rd_n(PDM_OFS_LONGEST_B0, 2, v);
        chk("longest", 32'h0000_0008, v);
        rd_n(PDM_OFS_LONGEST_B0, 2, v);
        chk("longest", 32'h0000_0000, v);
    endtask

    task automatic t_max();
        wr8(PDM_OFS_CONTROL, 8'h01);
        i_far.run(5, 0, 1'b0);
        i_far.run(9, 2, 1'b0);
        i_far.run(3, 0, 1'b0);
        wr8(PDM_OFS_CONTROL, 8'h00);
        rd_n(PDM_OFS_LONGEST_B0, 2, v);
        chk("longest", 32'h0000_0009, v);
        rd_n(PDM_OFS_REQ_TOTAL_B0, 4, v);
        chk("total", 32'h0000_0006, v);
    endtask

    task automatic t_frozen();
        i_far.run(12, 4, 1'b0);
        rd_n(PDM_OFS_REQ_TOTAL_B0, 4, v);
        chk("total", 32'h0000_0006, v);
        rd_n(PDM_OFS_LONGEST_B0, 2, v);
        chk("longest", 32'h0000_0000, v);
    endtask

    // ------------------------------------------------------------------
    // Run control.
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_control();
        t_count();
        t_max();
        t_frozen();
        conclude();
    end

endmodule

`default_nettype wire
